// *** include/cps_pkg.sv ***
// Shared constants for the converter management register bank
package cps_pkg;

  // Linear word helpers: fixed exponent above an unsigned mantissa
  localparam logic [4:0] EXP_M3 = 5'h1D;
  localparam logic [4:0] EXP_M2 = 5'h1E;
  localparam int VOUT_SCALE = 4096;
  localparam int LIN3_SCALE = 8;
  localparam int LIN2_SCALE = 4;
  localparam int MILLI = 1000;

  function automatic logic [15:0] lin3(input int milli);
    lin3 = {EXP_M3, 11'(milli * LIN3_SCALE / MILLI)};
  endfunction

  function automatic logic [15:0] lin2(input int milli);
    lin2 = {EXP_M2, 11'(milli * LIN2_SCALE / MILLI)};
  endfunction

  // Command codes handled outside the parameter table
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_FORMAT = 8'h20;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_BYTE0 = 8'h7A;

  // Read-only setpoint format: linear mode, exponent -12
  localparam logic [7:0] FORMAT_VALUE = 8'h14;

  // Parameter table indices and their command codes
  localparam int NPAR = 13;
  localparam logic [3:0] P_CTRL = 4'h0;
  localparam logic [3:0] P_GUARD = 4'h1;
  localparam logic [3:0] P_SET = 4'h2;
  localparam logic [3:0] P_MHI = 4'h3;
  localparam logic [3:0] P_MLO = 4'h4;
  localparam logic [3:0] P_VON = 4'h5;
  localparam logic [3:0] P_VOFF = 4'h6;
  localparam logic [3:0] P_OVL = 4'h7;
  localparam logic [3:0] P_OCF = 4'h8;
  localparam logic [3:0] P_OCW = 4'h9;
  localparam logic [3:0] P_OTF = 4'hA;
  localparam logic [3:0] P_OTW = 4'hB;
  localparam logic [3:0] P_VINOV = 4'hC;
  localparam logic [7:0] PAR_CODE [NPAR] = '{8'h01, 8'h10, 8'h21, 8'h25, 8'h26, 8'h35, 8'h36,
                                             8'h40, 8'h46, 8'h4A, 8'h4F, 8'h51, 8'h55};

  // Output control fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MARGIN_HI = 5;
  localparam int CTRL_MARGIN_LO = 3;
  localparam logic [2:0] MARGIN_LOW = 3'h3;
  localparam logic [2:0] MARGIN_HIGH = 3'h5;
  localparam logic [15:0] CTRL_MASK = 16'h00B8;
  localparam int GUARD_BIT = 7;
  localparam logic [15:0] GUARD_MASK = 16'h0080;

  // Range limits
  localparam logic [15:0] VOUT_MAX = 16'(12500 * VOUT_SCALE / MILLI);
  localparam logic [15:0] VOUT_MIN = 16'((10800 * VOUT_SCALE + MILLI - 1) / MILLI);
  localparam logic [15:0] OVL_MAX = 16'(14500 * VOUT_SCALE / MILLI);
  localparam logic [15:0] OVL_MIN = 16'(13000 * VOUT_SCALE / MILLI);
  localparam logic [16:0] OVL_HEADROOM = 17'(2300 * VOUT_SCALE / MILLI);
  localparam logic [15:0] VON_MAX = lin3(40000);
  localparam logic [15:0] VON_MIN = lin3(35000);
  localparam logic [15:0] VOFF_MAX = lin3(39000);
  localparam logic [15:0] VOFF_MIN = lin3(34000);
  localparam logic [16:0] VIN_HYST = 17'(1500 * LIN3_SCALE / MILLI);
  localparam logic [15:0] OCF_MAX = lin2(170000);
  localparam logic [15:0] OCF_MIN = lin2(150000);
  localparam logic [15:0] OCW_MAX = lin2(155000);
  localparam logic [15:0] OCW_MIN = lin2(145000);
  localparam logic [15:0] OTF_MAX = lin2(140000);
  localparam logic [15:0] OTW_MAX = lin2(120000);
  localparam logic [15:0] OT_MIN = lin2(25000);
  localparam logic [15:0] VINOV_MAX = lin3(68000);
  localparam logic [15:0] VINOV_MIN = lin3(61000);

  // Reset and factory values of the parameter table
  localparam logic [15:0] DEF_VAL [NPAR] = '{16'h0080, 16'h0000, 16'hC2B8, VOUT_MAX, VOUT_MIN,
                                             lin3(36000), VOFF_MIN, OVL_MAX, OCF_MAX, OCW_MAX,
                                             OTF_MAX, OTW_MAX, VINOV_MAX};

  // Status bytes: index, supported bits and summary positions
  localparam int NST = 5;
  localparam logic [2:0] ST_VOUT = 3'h0;
  localparam logic [2:0] ST_IOUT = 3'h1;
  localparam logic [2:0] ST_INPUT = 3'h2;
  localparam logic [2:0] ST_TEMP = 3'h3;
  localparam logic [2:0] ST_CML = 3'h4;
  localparam logic [7:0] ST_MASK [NST] = '{8'hC0, 8'hA0, 8'hF0, 8'hC0, 8'hC0};
  localparam int FLT_BIT = 7;
  localparam int WARN_BIT = 6;
  localparam int IOUT_WARN_BIT = 5;
  localparam int UV_WARN_BIT = 5;
  localparam int UV_FLT_BIT = 4;
  localparam int SUM_OFF = 6;
  localparam int SUM_VOUT_OV = 5;
  localparam int SUM_IOUT_OC = 4;
  localparam int SUM_VIN_UV = 3;
  localparam int SUM_TEMP = 2;
  localparam int SUM_CML = 1;
  localparam int SUM_VOUT = 15;
  localparam int SUM_IOUT = 14;
  localparam int SUM_INPUT = 13;

endpackage

// *** rtl/cps_regs.sv ***
// Management register bank of the converter with a link-side command port
module cps_regs (
  // Controller clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link clock and reset
  input wire logic link_clk,
  input wire logic link_nrst,
  // Link command port
  input wire logic lk_req,
  input wire logic lk_write,
  input wire logic [7:0] lk_code,
  input wire logic [15:0] lk_wdata,
  output logic lk_busy,
  output logic lk_done,
  output logic [15:0] lk_rdata,
  output logic lk_refused,
  // Fault and warning events from the converter
  input wire logic ev_vout_ov_fault,
  input wire logic ev_vout_ov_warn,
  input wire logic ev_iout_oc_fault,
  input wire logic ev_iout_oc_warn,
  input wire logic ev_vin_ov_fault,
  input wire logic ev_vin_ov_warn,
  input wire logic ev_vin_uv_warn,
  input wire logic ev_vin_uv_fault,
  input wire logic ev_ot_fault,
  input wire logic ev_ot_warn,
  // Settings to the converter
  output logic output_enable,
  output logic [15:0] active_setpoint,
  output logic [15:0] ov_limit_eff,
  output logic [15:0] vin_on_level,
  output logic [15:0] vin_off_level,
  output logic [15:0] oc_fault_level,
  output logic [15:0] oc_warn_level,
  output logic [15:0] ot_fault_level,
  output logic [15:0] ot_warn_level,
  output logic [15:0] vin_ov_level
);

  typedef enum logic [0:0] {
    CPS_LK_IDLE = 1'b0,
    CPS_LK_WAIT = 1'b1
  } cps_lk_state_e;

  // Link domain state
  cps_lk_state_e lk_state, next_lk_state;
  logic req_tgl, next_req_tgl;
  logic cap_write, next_cap_write;
  logic [7:0] cap_code, next_cap_code;
  logic [15:0] cap_wdata, next_cap_wdata;
  logic ack_seen, next_ack_seen;
  logic ack_sync;
  logic next_lk_done;
  logic [15:0] next_lk_rdata;
  logic next_lk_refused;

  // Controller domain state
  logic req_sync;
  logic req_seen;
  logic ack_tgl, next_ack_tgl;
  logic [15:0] rsp_data, next_rsp_data;
  logic rsp_refused, next_rsp_refused;
  logic [15:0] par [cps_pkg::NPAR];
  logic [15:0] next_par [cps_pkg::NPAR];
  logic [15:0] nvm [cps_pkg::NPAR];
  logic [15:0] next_nvm [cps_pkg::NPAR];
  logic [7:0] st [cps_pkg::NST];
  logic [7:0] next_st [cps_pkg::NST];
  logic [15:0] next_active_setpoint;
  logic [15:0] next_ov_limit_eff;

  // Decode helpers
  logic req_new;
  logic hit;
  logic [3:0] hit_idx;
  logic is_status_byte;
  logic [2:0] st_idx;
  logic wr_ok;
  logic [7:0] ev [cps_pkg::NST];
  logic [7:0] clr [cps_pkg::NST];
  logic [15:0] summary;
  logic bad_cmd;
  logic bad_data;
  logic [16:0] ovl_cap;
  logic [2:0] margin_sel;

  // Link side: take a request, hold it, wait for the answer
  always_comb
  begin
    next_lk_state = lk_state;
    next_req_tgl = req_tgl;
    next_cap_write = cap_write;
    next_cap_code = cap_code;
    next_cap_wdata = cap_wdata;
    next_ack_seen = ack_sync;
    next_lk_done = 1'b0;
    next_lk_rdata = lk_rdata;
    next_lk_refused = lk_refused;
    unique case (lk_state)
      CPS_LK_IDLE:
      begin
        if (lk_req)
        begin
          next_cap_write = lk_write;
          next_cap_code = lk_code;
          next_cap_wdata = lk_wdata;
          next_req_tgl = ~req_tgl;
          next_lk_state = CPS_LK_WAIT;
        end
      end
      CPS_LK_WAIT:
      begin
        if (ack_sync != ack_seen)
        begin
          next_lk_done = 1'b1;
          next_lk_rdata = rsp_data;
          next_lk_refused = rsp_refused;
          next_lk_state = CPS_LK_IDLE;
        end
      end
    endcase
  end

  // Link side registers
  always_ff @(posedge link_clk)
  begin
    if (!link_nrst)
    begin
      lk_state <= CPS_LK_IDLE;
      req_tgl <= 1'b0;
      cap_write <= 1'b0;
      cap_code <= 8'h00;
      cap_wdata <= 16'h0000;
      ack_seen <= 1'b0;
      lk_done <= 1'b0;
      lk_rdata <= 16'h0000;
      lk_refused <= 1'b0;
    end
    else
    begin
      lk_state <= next_lk_state;
      req_tgl <= next_req_tgl;
      cap_write <= next_cap_write;
      cap_code <= next_cap_code;
      cap_wdata <= next_cap_wdata;
      ack_seen <= next_ack_seen;
      lk_done <= next_lk_done;
      lk_rdata <= next_lk_rdata;
      lk_refused <= next_lk_refused;
    end
  end

  assign lk_busy = (lk_state == CPS_LK_WAIT);

  // Request toggle into the controller domain
  cps_sync #(.WIDTH(1)) u_req_sync (
    .clk(clk),
    .rst_n(nrst),
    .din(req_tgl),
    .dout(req_sync)
  );

  // Answer toggle back into the link domain
  cps_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk),
    .rst_n(link_nrst),
    .din(ack_tgl),
    .dout(ack_sync)
  );

  assign req_new = req_sync ^ req_seen;

  // Command decode: parameter table or status byte
  always_comb
  begin
    hit = 1'b0;
    hit_idx = 4'h0;
    for (int i = 0; i < cps_pkg::NPAR; i++)
    begin
      if (cap_code == cps_pkg::PAR_CODE[i])
      begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
    st_idx = 3'(cap_code - cps_pkg::CMD_STATUS_BYTE0);
    is_status_byte = (cap_code >= cps_pkg::CMD_STATUS_BYTE0) &&
                     (cap_code < cps_pkg::CMD_STATUS_BYTE0 + 8'(cps_pkg::NST));
  end

  // Range and cross checks on a written value
  always_comb
  begin
    wr_ok = 1'b1;
    case (hit_idx)
      cps_pkg::P_SET: wr_ok = cap_wdata >= cps_pkg::VOUT_MIN && cap_wdata <= cps_pkg::VOUT_MAX;
      cps_pkg::P_MHI: wr_ok = cap_wdata >= cps_pkg::VOUT_MIN && cap_wdata <= cps_pkg::VOUT_MAX &&
                              cap_wdata > par[cps_pkg::P_MLO];
      cps_pkg::P_MLO: wr_ok = cap_wdata >= cps_pkg::VOUT_MIN && cap_wdata <= cps_pkg::VOUT_MAX &&
                              cap_wdata < par[cps_pkg::P_MHI];
      cps_pkg::P_VON: wr_ok = cap_wdata >= cps_pkg::VON_MIN && cap_wdata <= cps_pkg::VON_MAX &&
                              17'(cap_wdata) >= 17'(par[cps_pkg::P_VOFF]) + cps_pkg::VIN_HYST;
      cps_pkg::P_VOFF: wr_ok = cap_wdata >= cps_pkg::VOFF_MIN && cap_wdata <= cps_pkg::VOFF_MAX &&
                               17'(par[cps_pkg::P_VON]) >= 17'(cap_wdata) + cps_pkg::VIN_HYST;
      cps_pkg::P_OVL: wr_ok = cap_wdata >= cps_pkg::OVL_MIN && cap_wdata <= cps_pkg::OVL_MAX &&
                              cap_wdata > par[cps_pkg::P_SET];
      cps_pkg::P_OCF: wr_ok = cap_wdata >= cps_pkg::OCF_MIN && cap_wdata <= cps_pkg::OCF_MAX &&
                              cap_wdata > par[cps_pkg::P_OCW];
      cps_pkg::P_OCW: wr_ok = cap_wdata >= cps_pkg::OCW_MIN && cap_wdata <= cps_pkg::OCW_MAX &&
                              cap_wdata < par[cps_pkg::P_OCF];
      cps_pkg::P_OTF: wr_ok = cap_wdata >= cps_pkg::OT_MIN && cap_wdata <= cps_pkg::OTF_MAX &&
                              cap_wdata > par[cps_pkg::P_OTW];
      cps_pkg::P_OTW: wr_ok = cap_wdata >= cps_pkg::OT_MIN && cap_wdata <= cps_pkg::OTW_MAX &&
                              cap_wdata < par[cps_pkg::P_OTF];
      cps_pkg::P_VINOV: wr_ok = cap_wdata >= cps_pkg::VINOV_MIN && cap_wdata <= cps_pkg::VINOV_MAX;
      default: wr_ok = 1'b1;
    endcase
  end

  // Status summary word built from the sticky bytes and the output enable bit
  always_comb
  begin
    summary = 16'h0000;
    summary[cps_pkg::SUM_OFF] = ~par[cps_pkg::P_CTRL][cps_pkg::CTRL_EN_BIT];
    summary[cps_pkg::SUM_VOUT_OV] = st[cps_pkg::ST_VOUT][cps_pkg::FLT_BIT];
    summary[cps_pkg::SUM_IOUT_OC] = st[cps_pkg::ST_IOUT][cps_pkg::FLT_BIT];
    summary[cps_pkg::SUM_VIN_UV] = st[cps_pkg::ST_INPUT][cps_pkg::UV_FLT_BIT];
    summary[cps_pkg::SUM_TEMP] = |st[cps_pkg::ST_TEMP];
    summary[cps_pkg::SUM_CML] = |st[cps_pkg::ST_CML];
    summary[cps_pkg::SUM_VOUT] = |st[cps_pkg::ST_VOUT];
    summary[cps_pkg::SUM_IOUT] = |st[cps_pkg::ST_IOUT];
    summary[cps_pkg::SUM_INPUT] = |st[cps_pkg::ST_INPUT];
  end

  // Command execution, parameter storage and sticky status
  always_comb
  begin
    next_ack_tgl = ack_tgl;
    next_rsp_data = rsp_data;
    next_rsp_refused = rsp_refused;
    next_par = par;
    next_nvm = nvm;
    bad_cmd = 1'b0;
    bad_data = 1'b0;
    for (int i = 0; i < cps_pkg::NST; i++)
    begin
      clr[i] = 8'h00;
    end
    if (req_new)
    begin
      next_ack_tgl = ~ack_tgl;
      next_rsp_data = 16'h0000;
      if (cap_write)
      begin
        if (par[cps_pkg::P_GUARD][cps_pkg::GUARD_BIT] && !(hit && hit_idx == cps_pkg::P_GUARD))
        begin
          bad_data = 1'b1;
        end
        else if (cap_code == cps_pkg::CMD_CLEAR_FAULTS)
        begin
          for (int i = 0; i < cps_pkg::NST; i++)
          begin
            clr[i] = 8'hFF;
          end
        end
        else if (cap_code == cps_pkg::CMD_STORE_ALL)
        begin
          next_nvm = par;
        end
        else if (cap_code == cps_pkg::CMD_RESTORE_ALL)
        begin
          next_par = nvm;
        end
        else if (is_status_byte)
        begin
          clr[st_idx] = cap_wdata[7:0];
        end
        else if (hit && wr_ok)
        begin
          next_par[hit_idx] = cap_wdata;
          // enable bit and margin field kept, reserved bits dropped
          if (hit_idx == cps_pkg::P_CTRL)
          begin
            next_par[hit_idx] = cap_wdata & cps_pkg::CTRL_MASK;
          end
          // only the guard bit is kept
          if (hit_idx == cps_pkg::P_GUARD)
          begin
            next_par[hit_idx] = cap_wdata & cps_pkg::GUARD_MASK;
          end
        end
        else if (hit || cap_code == cps_pkg::CMD_FORMAT || cap_code == cps_pkg::CMD_STATUS_WORD)
        begin
          bad_data = 1'b1;
        end
        else
        begin
          bad_cmd = 1'b1;
        end
      end
      else if (hit)
      begin
        next_rsp_data = par[hit_idx];
      end
      else if (cap_code == cps_pkg::CMD_FORMAT)
      begin
        next_rsp_data = {8'h00, cps_pkg::FORMAT_VALUE};
      end
      else if (cap_code == cps_pkg::CMD_STATUS_WORD)
      begin
        next_rsp_data = summary;
      end
      else if (is_status_byte)
      begin
        next_rsp_data = {8'h00, st[st_idx]};
      end
      else
      begin
        bad_cmd = 1'b1;
      end
      next_rsp_refused = bad_cmd | bad_data;
    end
  end

  // Event vectors in status byte layout
  always_comb
  begin
    for (int i = 0; i < cps_pkg::NST; i++)
    begin
      ev[i] = 8'h00;
    end
    ev[cps_pkg::ST_VOUT][cps_pkg::FLT_BIT] = ev_vout_ov_fault;
    ev[cps_pkg::ST_VOUT][cps_pkg::WARN_BIT] = ev_vout_ov_warn;
    ev[cps_pkg::ST_IOUT][cps_pkg::FLT_BIT] = ev_iout_oc_fault;
    ev[cps_pkg::ST_IOUT][cps_pkg::IOUT_WARN_BIT] = ev_iout_oc_warn;
    ev[cps_pkg::ST_INPUT][cps_pkg::FLT_BIT] = ev_vin_ov_fault;
    ev[cps_pkg::ST_INPUT][cps_pkg::WARN_BIT] = ev_vin_ov_warn;
    ev[cps_pkg::ST_INPUT][cps_pkg::UV_WARN_BIT] = ev_vin_uv_warn;
    ev[cps_pkg::ST_INPUT][cps_pkg::UV_FLT_BIT] = ev_vin_uv_fault;
    ev[cps_pkg::ST_TEMP][cps_pkg::FLT_BIT] = ev_ot_fault;
    ev[cps_pkg::ST_TEMP][cps_pkg::WARN_BIT] = ev_ot_warn;
    ev[cps_pkg::ST_CML][cps_pkg::FLT_BIT] = bad_cmd;
    ev[cps_pkg::ST_CML][cps_pkg::WARN_BIT] = bad_data;
    for (int i = 0; i < cps_pkg::NST; i++)
    begin
      next_st[i] = ((st[i] & ~clr[i]) | ev[i]) & cps_pkg::ST_MASK[i];
    end
  end

  // Setpoint selection and over-voltage limit clamp
  always_comb
  begin
    margin_sel = par[cps_pkg::P_CTRL][cps_pkg::CTRL_MARGIN_HI:cps_pkg::CTRL_MARGIN_LO];
    if (margin_sel == cps_pkg::MARGIN_LOW)
    begin
      next_active_setpoint = par[cps_pkg::P_MLO];
    end
    else if (margin_sel == cps_pkg::MARGIN_HIGH)
    begin
      next_active_setpoint = par[cps_pkg::P_MHI];
    end
    else
    begin
      next_active_setpoint = par[cps_pkg::P_SET];
    end
    ovl_cap = 17'(par[cps_pkg::P_SET]) + cps_pkg::OVL_HEADROOM;
    next_ov_limit_eff = par[cps_pkg::P_OVL];
    if (ovl_cap < 17'(next_ov_limit_eff))
    begin
      next_ov_limit_eff = ovl_cap[15:0];
    end
    if (next_ov_limit_eff > cps_pkg::OVL_MAX)
    begin
      next_ov_limit_eff = cps_pkg::OVL_MAX;
    end
  end

  // Controller domain registers; reset stands for loss of bias
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_refused <= 1'b0;
      par <= cps_pkg::DEF_VAL;
      nvm <= cps_pkg::DEF_VAL;
      for (int i = 0; i < cps_pkg::NST; i++)
      begin
        st[i] <= 8'h00;
      end
      active_setpoint <= 16'h0000;
      ov_limit_eff <= 16'h0000;
    end
    else
    begin
      req_seen <= req_sync;
      ack_tgl <= next_ack_tgl;
      rsp_data <= next_rsp_data;
      rsp_refused <= next_rsp_refused;
      par <= next_par;
      nvm <= next_nvm;
      st <= next_st;
      active_setpoint <= next_active_setpoint;
      ov_limit_eff <= next_ov_limit_eff;
    end
  end

  // Settings straight from the parameter flops
  // output enable bit
  assign output_enable = par[cps_pkg::P_CTRL][cps_pkg::CTRL_EN_BIT];
  assign vin_on_level = par[cps_pkg::P_VON];
  assign vin_off_level = par[cps_pkg::P_VOFF];
  assign oc_fault_level = par[cps_pkg::P_OCF];
  assign oc_warn_level = par[cps_pkg::P_OCW];
  assign ot_fault_level = par[cps_pkg::P_OTF];
  assign ot_warn_level = par[cps_pkg::P_OTW];
  assign vin_ov_level = par[cps_pkg::P_VINOV];

endmodule

// *** rtl/cps_sync.sv ***
// Two-flop synchroniser for levels and toggles entering a clock domain
module cps_sync #(
  parameter int WIDTH = 1
) (
  // Destination domain
  input wire logic clk,
  input wire logic rst_n,
  // Crossing signal
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// *** tb/cps_host.sv ***
// Host controller model driving the link command port
module cps_host (
  // Link clock
  input wire logic link_clk,
  // Requests
  output logic lk_req,
  output logic lk_write,
  output logic [7:0] lk_code,
  output logic [15:0] lk_wdata,
  // Answers
  input wire logic lk_busy,
  input wire logic lk_done,
  input wire logic [15:0] lk_rdata,
  input wire logic lk_refused
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  // Idle link
  initial
  begin
    lk_req = 1'b0;
    lk_write = 1'b0;
    lk_code = 8'h00;
    lk_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
    output logic [15:0] rd, output logic rf, output bit ok);
    int n;
    ok = 0;
    rd = 16'h0000;
    rf = 1'b0;
    repeat (gap) @(negedge link_clk);
    lk_req = 1'b1;
    lk_write = w;
    lk_code = c;
    lk_wdata = d;
    @(posedge link_clk);
    @(negedge link_clk);
    lk_req = 1'b0;
    lk_code = ~c; // Released code and data lines do not keep the old value
    lk_wdata = ~d;
    // Answer sampled off the launching edge, so the next request also starts there
    for (n = 0; n < 8 && !ok; n++)
    begin
      @(negedge link_clk);
      if (lk_done === 1'b1)
      begin
        ok = 1;
        rd = lk_rdata;
        rf = lk_refused;
      end
    end
  endtask
endmodule

// *** tb/cps_regs_checker.sv ***
// Port-level assertions for the converter register bank
module cps_regs_checker (
  // Clocks and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  // Link port
  input wire logic lk_req,
  input wire logic lk_busy,
  input wire logic lk_done,
  input wire logic [15:0] lk_rdata,
  // Settings to the converter
  input wire logic [15:0] active_setpoint,
  input wire logic [15:0] ov_limit_eff,
  input wire logic [15:0] vin_on_level,
  input wire logic [15:0] vin_off_level,
  input wire logic [15:0] oc_fault_level,
  input wire logic [15:0] oc_warn_level,
  input wire logic [15:0] ot_fault_level,
  input wire logic [15:0] ot_warn_level,
  input wire logic [15:0] vin_ov_level
);
  // Answer window of a taken request
  sequence s_answer;
    ##[1:8] lk_done;
  endsequence
  // Link handshake checks
  a_req_answer: assert property (@(posedge link_clk) disable iff (!link_nrst)
    lk_req && !lk_busy |-> s_answer) else $error("request not answered");
  a_done_pulse: assert property (@(posedge link_clk) disable iff (!link_nrst)
    lk_done |=> !lk_done) else $error("done longer than one cycle");
  a_busy_done: assert property (@(posedge link_clk) disable iff (!link_nrst)
    $fell(lk_busy) |-> lk_done) else $error("busy dropped without done");
  a_rdata_hold: assert property (@(posedge link_clk) disable iff (!link_nrst)
    !$stable(lk_rdata) |-> lk_done) else $error("read data moved without done");
  // Limit checks, skipping the edge right after reset release
  a_sp_range: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> active_setpoint inside {[cps_pkg::VOUT_MIN:cps_pkg::VOUT_MAX]}) else $error("setpoint range");
  a_ovl_cap: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> ov_limit_eff inside {[cps_pkg::OVL_MIN:cps_pkg::OVL_MAX]}) else $error("ov limit cap");
  a_vin_hyst: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> {1'b0, vin_on_level} >= {1'b0, vin_off_level} + cps_pkg::VIN_HYST) else $error("vin gap");
  a_oc_order: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> oc_fault_level > oc_warn_level && oc_fault_level <= cps_pkg::OCF_MAX) else $error("oc order");
  a_ot_order: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> ot_fault_level > ot_warn_level && ot_warn_level >= cps_pkg::OT_MIN) else $error("ot order");
  a_vinov_range: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> vin_ov_level inside {[cps_pkg::VINOV_MIN:cps_pkg::VINOV_MAX]}) else $error("vin ov range");
endmodule
bind cps_regs cps_regs_checker u_cps_regs_checker (.clk, .nrst, .link_clk, .link_nrst, .lk_req, .lk_busy,
  .lk_done, .lk_rdata, .active_setpoint, .ov_limit_eff, .vin_on_level, .vin_off_level, .oc_fault_level,
  .oc_warn_level, .ot_fault_level, .ot_warn_level, .vin_ov_level);

// *** tb/tb.sv ***
// Self-checking bench for the converter register bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] e; logic r;} cps_row_s;
  logic clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, link_nrst = 1'b0;
  logic lk_req, lk_write, lk_busy, lk_done, lk_refused, output_enable;
  logic [7:0] lk_code;
  logic [9:0] ev = 10'h000;
  logic [15:0] lk_wdata, lk_rdata, active_setpoint, ov_limit_eff;
  int errors = 0, total_checks = 0;
  cps_row_s rows [22] = '{
    '{0, 8'h20, 16'h0000, 16'h0014, 0}, '{1, 8'h20, 16'h0000, 16'h0000, 1},
    '{0, 8'h21, 16'h0000, 16'hC2B8, 0}, '{1, 8'h21, 16'hC801, 16'h0000, 1},
    '{1, 8'h26, 16'hC800, 16'h0000, 1}, '{1, 8'h25, 16'hACCD, 16'h0000, 1},
    '{1, 8'h35, 16'hE918, 16'h0000, 1}, '{1, 8'h35, 16'hE91C, 16'h0000, 0},
    '{1, 8'h36, 16'hE911, 16'h0000, 1}, '{1, 8'h40, 16'hE801, 16'h0000, 1},
    '{1, 8'h40, 16'hD000, 16'h0000, 0}, '{1, 8'h46, 16'hF26C, 16'h0000, 1},
    '{1, 8'h4A, 16'hF270, 16'h0000, 1}, '{1, 8'h51, 16'hF230, 16'h0000, 1},
    '{1, 8'h4F, 16'hF063, 16'h0000, 1}, '{1, 8'h55, 16'hE9E7, 16'h0000, 1},
    '{1, 8'h55, 16'hE9E8, 16'h0000, 0}, '{0, 8'h55, 16'h0000, 16'hE9E8, 0},
    '{0, 8'h80, 16'h0000, 16'h0000, 1}, '{1, 8'h10, 16'h0080, 16'h0000, 0},
    '{1, 8'h21, 16'hC000, 16'h0000, 1}, '{1, 8'h10, 16'h0000, 16'h0000, 0}};
  // Controller and link clocks
  always #2 clk = ~clk;
  always #62.5 link_clk = ~link_clk;
  cps_regs u_cps_regs (.clk(clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst), .lk_req(lk_req),
    .lk_write(lk_write), .lk_code(lk_code), .lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_done(lk_done),
    .lk_rdata(lk_rdata), .lk_refused(lk_refused), .ev_vout_ov_fault(ev[0]), .ev_vout_ov_warn(ev[1]),
    .ev_iout_oc_fault(ev[2]), .ev_iout_oc_warn(ev[3]), .ev_vin_ov_fault(ev[4]), .ev_vin_ov_warn(ev[5]),
    .ev_vin_uv_warn(ev[6]), .ev_vin_uv_fault(ev[7]), .ev_ot_fault(ev[8]), .ev_ot_warn(ev[9]),
    .output_enable(output_enable), .active_setpoint(active_setpoint), .ov_limit_eff(ov_limit_eff),
    .vin_on_level(), .vin_off_level(), .oc_fault_level(), .oc_warn_level(), .ot_fault_level(),
    .ot_warn_level(), .vin_ov_level());
  cps_host u_cps_host (.link_clk(link_clk), .lk_req(lk_req), .lk_write(lk_write), .lk_code(lk_code),
    .lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_done(lk_done), .lk_rdata(lk_rdata), .lk_refused(lk_refused));
  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [15:0] e, input logic r);
    logic [15:0] rd;
    logic rf;
    bit ok;
    u_cps_host.xfer(w, c, d, rd, rf, ok);
    if (!ok)
    begin
      errors++;
      final_report();
    end
    else
      chk({rf, rd}, {r, e});
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    link_nrst = 1'b0;
    repeat (3) @(negedge link_clk);
    @(negedge clk);
    nrst = 1'b1;
    @(negedge link_clk);
    link_nrst = 1'b1;
  endtask
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask
  // Main sequence
  initial
  begin
    do_reset();
    for (int i = 0; i < cps_pkg::NPAR; i++)
      op(0, cps_pkg::PAR_CODE[i], 16'h0000, cps_pkg::DEF_VAL[i], 0);
    foreach (rows[i])
      op(rows[i].w, rows[i].c, rows[i].d, rows[i].e, rows[i].r);
    settle();
    chk({1'b0, ov_limit_eff}, {1'b0, 16'hD000});
    op(1, 8'h40, 16'hE800, 16'h0000, 0);
    settle();
    chk({1'b0, ov_limit_eff}, {1'b0, 16'hE784});
    op(1, 8'h21, 16'hC400, 16'h0000, 0);
    settle();
    chk({1'b0, ov_limit_eff}, {1'b0, 16'hE800});
    op(1, 8'h01, 16'h0098, 16'h0000, 0);
    settle();
    chk({output_enable, active_setpoint}, {1'b1, 16'hACCD});
    u_cps_host.gap = 3;
    op(1, 8'h01, 16'h00A8, 16'h0000, 0);
    settle();
    chk({output_enable, active_setpoint}, {1'b1, 16'hC800});
    op(1, 8'h01, 16'h0000, 16'h0000, 0);
    settle();
    chk({output_enable, active_setpoint}, {1'b0, 16'hC400});
    u_cps_host.gap = 0;
    op(0, 8'h7E, 16'h0000, 16'h00C0, 0);
    op(0, 8'h79, 16'h0000, 16'h0042, 0);
    op(1, 8'h03, 16'h0000, 16'h0000, 0);
    @(negedge clk);
    ev = 10'h3FF;
    @(negedge clk);
    ev = 10'h000;
    settle();
    op(0, 8'h7A, 16'h0000, 16'h00C0, 0);
    op(0, 8'h7B, 16'h0000, 16'h00A0, 0);
    op(0, 8'h7C, 16'h0000, 16'h00F0, 0);
    op(0, 8'h7D, 16'h0000, 16'h00C0, 0);
    op(0, 8'h7E, 16'h0000, 16'h0000, 0);
    op(0, 8'h79, 16'h0000, 16'hE07C, 0);
    op(1, 8'h7A, 16'h0080, 16'h0000, 0);
    op(0, 8'h7A, 16'h0000, 16'h0040, 0);
    op(1, 8'h03, 16'h0000, 16'h0000, 0);
    op(0, 8'h7C, 16'h0000, 16'h0000, 0);
    op(1, 8'h21, 16'hC000, 16'h0000, 0);
    op(1, 8'h11, 16'h0000, 16'h0000, 0);
    op(1, 8'h21, 16'hBC00, 16'h0000, 0);
    op(0, 8'h21, 16'h0000, 16'hBC00, 0);
    op(1, 8'h12, 16'h0000, 16'h0000, 0);
    op(0, 8'h21, 16'h0000, 16'hC000, 0);
    @(negedge clk);
    ev = 10'h005;
    @(negedge clk);
    ev = 10'h000;
    do_reset();
    op(0, 8'h7A, 16'h0000, 16'h0000, 0);
    op(0, 8'h21, 16'h0000, 16'hC2B8, 0);
    op(0, 8'h01, 16'h0000, 16'h0080, 0);
    final_report();
  end
endmodule
